/* File: hdl/sbp_port.sv */
// synchronous burst-of-two sram device with an apb side window
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "sbp_map.svh"

module sbp_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic c_n,
    input wire logic rd_sel_n,
    input wire logic wr_sel_n,
    input wire logic lane_mask_0_n,
    input wire logic lane_mask_1_n,
    input wire logic dll_off_n,
    input wire logic [1:0] nc_ball,
    input wire logic [19:0] addr,
    input wire logic [7:0] d,
    output sbp_pkg::sbp_word_t q,
    output logic q_oe_n
);
    import sbp_pkg::*;

    logic [`SBP_SYNC_W-1:0] sync1_r;
    logic [`SBP_SYNC_W-1:0] sync2_r;
    logic k_q_r;
    logic kn_q_r;
    logic c_q_r;
    logic cn_q_r;
    logic k_s, kn_s, c_s, cn_s, rd_n_s, wr_n_s, m0_s, m1_s, dll_n_s;
    logic [1:0] nc_s;
    logic [19:0] addr_s;
    logic [7:0] d_s;
    logic k_rise, kn_rise, oref0_rise, oref1_rise, out_from_k;

    sbp_word_t mem [0:(1<<`SBP_MEM_AW)-1];

    logic wr_pend_r;
    sbp_word_t wr_d0_r;
    logic [1:0] wr_m0_r;
    logic rd_acc_r;
    logic [19:0] rd_acc_addr_r;
    logic rd_out_r;
    logic [19:0] rd_out_addr_r;
    sbp_out_st_t out_st_r;
    logic [19:0] out_addr_r;
    logic [15:0] stop_cnt_r;
    logic clk_stop;
    logic [20:0] mem_addr_r;
    logic apb_wr, apb_rd, addr_ok;
    logic link_wr0, link_wr1;
    logic [20:0] link_base;
    sbp_word_t wr_d1_merged;

    // two flip-flop synchroniser on every pin input
    // it resets to the idle pin levels, so no false edge follows reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= `SBP_SYNC_RST;
            sync2_r <= `SBP_SYNC_RST;
        end
        else
        begin
            sync1_r <= {k, k_n, c, c_n, rd_sel_n, wr_sel_n, lane_mask_0_n,
                        lane_mask_1_n, dll_off_n, nc_ball, addr, d};
            sync2_r <= sync1_r;
        end
    end

    assign {k_s, kn_s, c_s, cn_s, rd_n_s, wr_n_s, m0_s, m1_s, dll_n_s,
            nc_s, addr_s, d_s} = sync2_r;

    // previous clock levels for edge finding
    // complement clocks idle high, so their history starts high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            k_q_r <= 1'b0;
            kn_q_r <= 1'b1;
            c_q_r <= 1'b0;
            cn_q_r <= 1'b1;
        end
        else
        begin
            k_q_r <= k_s;
            kn_q_r <= kn_s;
            c_q_r <= c_s;
            cn_q_r <= cn_s;
        end
    end

    // edge detection and output reference choice
    // both c pins high only means tied high, never a running pair
    // c pair held high selects k timing
    assign out_from_k = c_s & cn_s;
    assign k_rise = k_s & ~k_q_r;
    assign kn_rise = kn_s & ~kn_q_r;
    assign oref0_rise = out_from_k ? k_rise : (c_s & ~c_q_r);
    assign oref1_rise = out_from_k ? kn_rise : (cn_s & ~cn_q_r);

    // threshold spans several k periods; the counter saturates there
    // stopped clocks only raise a status flag, state is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stop_cnt_r <= 16'h0000;
        else if (k_rise)
            stop_cnt_r <= 16'h0000;
        else if (!clk_stop)
            stop_cnt_r <= stop_cnt_r + 16'h0001;
    end

    // flag only; the sequencers simply wait for the next edge
    assign clk_stop = (stop_cnt_r >= 16'(`SBP_STOP_CYC));

    // write sequencer: beat 0 on k, address and beat 1 on k_n
    // the pending flag spans exactly one k half period
    // selects sampled on k rise only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_pend_r <= 1'b0;
            wr_d0_r <= 8'h00;
            wr_m0_r <= 2'h3;
        end
        else if (k_rise)
        begin
            wr_pend_r <= ~wr_n_s;
            wr_d0_r <= d_s;
            wr_m0_r <= {m1_s, m0_s};
        end
        else if (kn_rise)
            wr_pend_r <= 1'b0;
    end

    assign link_base = {addr_s, 1'b0};
    // beat 1 taken on the k_n rise
    assign link_wr0 = kn_rise & wr_pend_r;
    assign link_wr1 = kn_rise & wr_pend_r;
    assign apb_wr = psel & penable & pwrite & addr_ok
                    & (paddr == `SBP_OFF_MEM_DATA);

    // beat 1 keeps the old nibble wherever its mask is high
    // nibble lanes for beat 1
    always_comb
    begin
        wr_d1_merged = mem[link_base | 21'h000001];
        if (!m0_s)
            wr_d1_merged[3:0] = d_s[3:0];
        if (!m1_s)
            wr_d1_merged[7:4] = d_s[7:4];
    end

    // array writes, link first, apb window otherwise
    // a link write and an apb data write in one cycle drop the apb one
    always_ff @(posedge pclk)
    begin
        if (link_wr0)
        begin
            if (!wr_m0_r[0])
                mem[link_base][3:0] <= wr_d0_r[3:0];
            if (!wr_m0_r[1])
                mem[link_base][7:4] <= wr_d0_r[7:4];
        end
        if (link_wr1)
            mem[link_base | 21'h000001] <= wr_d1_merged;
        if (apb_wr && !link_wr0)
            mem[mem_addr_r] <= pwdata[7:0];
    end

    // read sequencer pipeline, one k period per stage
    // a read accepted at a k rise is handed on at the next k rise
    // runs apart from the write sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_acc_r <= 1'b0;
            rd_acc_addr_r <= 20'h00000;
            rd_out_r <= 1'b0;
            rd_out_addr_r <= 20'h00000;
        end
        else if (k_rise)
        begin
            // accept at t, deliver from t+1
            rd_acc_r <= ~rd_n_s;
            rd_acc_addr_r <= addr_s;
            rd_out_r <= rd_acc_r;
            rd_out_addr_r <= rd_acc_addr_r;
        end
    end

    // output phase machine
    // w1 chains straight into w0 for back to back reads
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_st_r <= SBP_OUT_IDLE;
            out_addr_r <= 20'h00000;
        end
        else
        begin
            case (out_st_r)
                SBP_OUT_IDLE:
                begin
                    if (oref1_rise && rd_out_r)
                    begin
                        out_st_r <= SBP_OUT_W0;
                        out_addr_r <= rd_out_addr_r;
                    end
                end
                SBP_OUT_W0:
                begin
                    if (oref0_rise)
                        out_st_r <= SBP_OUT_W1;
                end
                SBP_OUT_W1:
                begin
                    if (oref1_rise)
                    begin
                        out_st_r <= rd_out_r ? SBP_OUT_W0 : SBP_OUT_IDLE;
                        out_addr_r <= rd_out_addr_r;
                    end
                end
                default:
                    out_st_r <= SBP_OUT_IDLE;
            endcase
        end
    end

    // data outputs launched on the reference edges
    // q_oe_n is reloaded on every first-word edge, so a gap floats q
    // float from reset until a read drives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= 8'h00;
            q_oe_n <= 1'b1;
        end
        else if (oref1_rise)
        begin
            q_oe_n <= ~rd_out_r;
            q <= rd_out_r ? mem[{rd_out_addr_r, 1'b0}] : 8'h00;
        end
        else if (oref0_rise && out_st_r == SBP_OUT_W0)
        begin
            q <= mem[{out_addr_r, 1'b1}];
        end
    end

    // apb window address register
    // the window index includes the internal low address bit
    assign addr_ok = (paddr == `SBP_OFF_STATUS) ||
                     (paddr == `SBP_OFF_MEM_ADDR) ||
                     (paddr == `SBP_OFF_MEM_DATA);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mem_addr_r <= `SBP_MEM_ADDR_RST;
        else if (psel && penable && pwrite && paddr == `SBP_OFF_MEM_ADDR)
            mem_addr_r <= pwdata[20:0];
    end

    // apb read data, zero wait states
    // loaded in setup so that it stands through the access phase
    assign pready = 1'b1;
    assign apb_rd = psel & ~penable & ~pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (apb_rd)
        begin
            case (paddr)
                `SBP_OFF_STATUS:
                begin
                    prdata <= 32'h00000000;
                    prdata[`SBP_ST_RD_BUSY] <= (out_st_r != SBP_OUT_IDLE)
                                               | rd_acc_r | rd_out_r;
                    prdata[`SBP_ST_WR_PEND] <= wr_pend_r;
                    prdata[`SBP_ST_DLL_BYP] <= ~dll_n_s;
                    prdata[`SBP_ST_OUT_K] <= out_from_k;
                    prdata[`SBP_ST_CLK_STOP] <= clk_stop;
                    prdata[`SBP_ST_NC_LO+1:`SBP_ST_NC_LO] <= nc_s;
                end
                `SBP_OFF_MEM_ADDR:
                    prdata <= {11'h000, mem_addr_r};
                `SBP_OFF_MEM_DATA:
                    prdata <= {24'h000000, mem[mem_addr_r]};
                default:
                    prdata <= 32'h00000000;
            endcase
        end
    end

    // unmapped addresses answer with an error
    // writes to unmapped offsets change nothing
    assign pslverr = psel & penable & ~addr_ok;

endmodule : sbp_port

/* File: hdl/sbp_map.svh */
// register offsets, field positions and timing counts of the burst port
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH

`define SBP_ADDR_W 20
`define SBP_DATA_W 8
`define SBP_MEM_AW 21
`define SBP_SYNC_W 39
// synchroniser reset: k_n, c_n, selects, masks and loop pin at idle high
`define SBP_SYNC_RST 39'h2FC0000000

`define SBP_OFF_STATUS 12'h000
`define SBP_OFF_MEM_ADDR 12'h004
`define SBP_OFF_MEM_DATA 12'h008

`define SBP_ST_RD_BUSY 0
`define SBP_ST_WR_PEND 1
`define SBP_ST_DLL_BYP 2
`define SBP_ST_OUT_K 3
`define SBP_ST_CLK_STOP 4
`define SBP_ST_NC_LO 5

`define SBP_MEM_ADDR_RST 21'h000000

`define SBP_STOP_TIME_NS 640
`define SBP_CLK_NS 10
`define SBP_STOP_CYC (`SBP_STOP_TIME_NS / `SBP_CLK_NS)

`endif

/* File: hdl/sbp_pkg.sv */
// types shared by the burst port
package sbp_pkg;

    typedef enum logic [2:0] {
        SBP_OUT_IDLE = 3'h1,
        SBP_OUT_W0 = 3'h2,
        SBP_OUT_W1 = 3'h4
    } sbp_out_st_t;

    typedef logic [7:0] sbp_word_t;

endpackage : sbp_pkg

/* File: tb/sbp_port_properties.sv */
// assertion checker for the burst port pins and apb side
`timescale 1ns/100ps
module sbp_port_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic k,
    input wire logic rd_sel_n,
    input wire logic dll_off_n,
    input wire logic [1:0] nc_ball,
    input wire logic q_oe_n
);
    logic k_r;
    logic [1:0] age_r;
    logic acc;
    logic st_rd;
    // access phase and status read decode
    assign acc = psel && penable;
    assign st_rd = acc && !pwrite && paddr == 12'h000;
    // k rises seen since the last read select, saturating at three
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {k_r, age_r} <= 3'h7;
        else
        begin
            k_r <= k;
            if (k && !k_r)
                age_r <= !rd_sel_n ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
        end
    end
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; acc |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready low in access");
    property p_err; acc && paddr > 12'h008 |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error on bad offset");
    property p_ok; acc && paddr[1:0] == 2'h0 && paddr <= 12'h008 |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("error on mapped offset");
    property p_idle; !acc |-> !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("error outside access");
    property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_oe; !q_oe_n |-> age_r != 2'h3; endproperty
    a_oe: assert property (p_oe) else $error("q driven with no read");
    property p_byp; st_rd |-> prdata[2] == !dll_off_n; endproperty
    a_byp: assert property (p_byp) else $error("bypass bit wrong");
    property p_nc; st_rd |-> prdata[6:5] == nc_ball; endproperty
    a_nc: assert property (p_nc) else $error("spare level wrong");
endmodule : sbp_port_chk

bind sbp_port sbp_port_chk i_sbp_port_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .k, .rd_sel_n, .dll_off_n,
    .nc_ball, .q_oe_n);

/* File: tb/sbp_ctl_model.sv */
// memory controller model driving the burst port pins
`timescale 1ns/100ps
module sbp_ctl_model (
    input wire logic tied,
    output logic k,
    output logic k_n,
    output logic c,
    output logic c_n,
    output logic rd_sel_n,
    output logic wr_sel_n,
    output logic lane_mask_0_n,
    output logic lane_mask_1_n,
    output logic [19:0] addr,
    output logic [7:0] d
);
    // tied is low for the first four bench loop passes, then high
    // output clocks follow k, or both sit high when tied
    assign c = tied | k;
    assign c_n = tied | k_n;
    // idle pins at power up
    initial
    begin
        {k, k_n, rd_sel_n, wr_sel_n, lane_mask_1_n, lane_mask_0_n} = 6'h1F;
        {addr, d} = '0;
    end
    // beat timing
    // one 125 ns k period: beat 0 at k rise, beat 1 at k_n rise
    // pins move off the pclk rises, which fall on 5 ns mod 10 ns
    task automatic period(logic rs, ws, logic [19:0] ra, wa,
        logic [7:0] d0, d1, logic [1:0] m0, m1);
        #1 {rd_sel_n, wr_sel_n, addr, d, lane_mask_1_n, lane_mask_0_n} =
            {rs, ws, ra, d0, m0};
        #30 {k, k_n} = 2'b10;
        #30 {rd_sel_n, wr_sel_n, addr, d, lane_mask_1_n, lane_mask_0_n} =
            {2'b11, wa, d1, m1};
        #32.5 {k, k_n} = 2'b01;
        #30 {addr, d} = ~{addr, d};
        #1.5;
    endtask : period
    // both selects high while data and masks are offered
    task automatic nop;
        period(1'b1, 1'b1, 20'h0, 20'h0, 8'hFF, 8'hFF, 2'h0, 2'h0);
    endtask : nop
    task automatic park;
        #1 {k, k_n} = 2'b10;
    endtask : park
endmodule : sbp_ctl_model

/* File: tb/tb_top.sv */
// self-checking bench for the burst port
`timescale 1ns/100ps
`include "sbp_map.svh"
module tb_top;
    import sbp_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, ev, tied;
    logic k, k_n, c, c_n, rd_sel_n, wr_sel_n, dll_off_n, q_oe_n, oea, oeb;
    logic lane_mask_0_n, lane_mask_1_n;
    logic [1:0] nc_ball;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv, ex;
    logic [19:0] addr, a, pa;
    logic [7:0] d, mem [int];
    sbp_word_t q, qa, qb;
    int err_total = 0;
    int n_tests = 0;
    // system clock
    always #5 pclk = ~pclk;
    sbp_port i_sbp_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .k, .k_n, .c, .c_n, .rd_sel_n,
        .wr_sel_n, .lane_mask_0_n, .lane_mask_1_n, .dll_off_n, .nc_ball,
        .addr, .d, .q, .q_oe_n);
    sbp_ctl_model i_sbp_ctl_model (.tied, .k, .k_n, .c, .c_n, .rd_sel_n,
        .wr_sel_n, .lane_mask_0_n, .lane_mask_1_n, .addr, .d);
    // sample read data late in each half of the output clock
    always @(posedge k_n) #55 {qa, oea} = {q, q_oe_n};
    always @(posedge k) #55 {qb, oeb} = {q, q_oe_n};
    function automatic logic [7:0] mg(logic [7:0] o, n, logic [1:0] m);
        return {m[1] ? o[7:4] : n[7:4], m[0] ? o[3:0] : n[3:0]};
    endfunction : mg
    task automatic chk(string s, logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(logic w, logic [11:0] ad, logic [31:0] wd);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 50 && pready !== 1'b1; n++)
            @(posedge pclk);
        {rdv, ev} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (n == 50)
        begin
            err_total++;
            finish_test();
        end
    endtask : apb
    // a link period, optional clock stop, then read result checks
    task automatic run(logic rs, ws, logic [19:0] ra, wa,
        logic [1:0] m0, m1, int gap);
        logic [7:0] d0, d1;
        {d0, d1} = 16'($urandom);
        i_sbp_ctl_model.period(rs, ws, ra, wa, d0, d1, m0, m1);
        if (!ws)
            mem[{wa, 1'b0}] = mg(mem[{wa, 1'b0}], d0, m0);
        if (!ws)
            mem[{wa, 1'b1}] = mg(mem[{wa, 1'b1}], d1, m1);
        #(gap);
        if (gap > 0)
            apb(1'b0, `SBP_OFF_STATUS, 32'h0);
        if (gap > 0)
            chk("stop flag", 32'h1, 32'(rdv[4]));
        if (gap > 0)
            chk("held read", 32'h1, 32'(rdv[0]));
        i_sbp_ctl_model.nop();
        i_sbp_ctl_model.nop();
        ex = 32'({mem[{ra, 1'b0}], mem[{ra, 1'b1}], 2'b00});
        if (!rs)
            chk("read burst", ex, 32'({qa, qb, oea, oeb}));
        i_sbp_ctl_model.nop();
        if (!rs)
            chk("q float", 32'h1, 32'(oea));
    endtask : run
    // main sequence
    initial
    begin
        void'($urandom(98282));
        {presetn, psel, penable, pwrite, paddr, pwdata, tied} = '0;
        {dll_off_n, nc_ball} = 3'($urandom);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk("oe at power up", 32'h1, 32'(q_oe_n));
        apb(1'b0, `SBP_OFF_STATUS, 32'h0);
        ex = 32'({!dll_off_n, nc_ball});
        chk("status pins", ex, 32'({rdv[2], rdv[6:5]}));
        apb(1'b0, `SBP_OFF_MEM_ADDR, 32'h0);
        chk("addr reset", 32'h0, rdv);
        apb(1'b1, 12'h00C, 32'h0);
        chk("unmapped", 32'h1, 32'(ev));
        for (int i = 0; i < 8; i++)
        begin
            a = 20'($urandom);
            tied = i[2];
            run(1'b1, 1'b0, ~a, a, 2'h0, 2'h0, 0);
            run(i == 0, 1'b0, pa, a, 2'(i), 2'($urandom), 0);
            run(1'b0, 1'b1, a, ~a, 2'h3, 2'h3, (i == 5) ? 1500 : 0);
            apb(1'b1, `SBP_OFF_MEM_ADDR, 32'({a, 1'b1}));
            apb(1'b0, `SBP_OFF_MEM_DATA, 32'h0);
            chk("array word", 32'(mem[{a, 1'b1}]), rdv);
            pa = a;
        end
        i_sbp_ctl_model.park();
        finish_test();
    end
    // cut a hung run short
    initial
    begin
        #100us;
        err_total++;
        finish_test();
    end
endmodule : tb_top
